/* File: hdl/pio_port_bank.sv */
// Parallel I/O port bank: direction, latch, pin read and pad ownership
//
// What this block does
// RULE1: A peripheral that is enabled and driving a pin owns its driver, yet the pin still reads.
// RULE2: A peripheral that is enabled but not driving leaves the pin to the port logic.
// RULE3: A direction bit of one makes the pin an input, zero makes it an output.
// RULE4: Every reset sets all implemented direction bits to one.
// RULE5: The latch register reads back the latch and is written by latch writes.
// RULE6: The pin register reads the current pin levels.
// RULE7: A write to the pin register stores into the latch instead.
// RULE8: Unimplemented bits read as zero in latch, direction and pin registers.
// RULE9: A pin shared only with an input function stays fully owned by the port.
// RULE10: Per pad, two muxes pick data and enable from peripheral or port, peripheral first.
// RULE11: Pin levels pass a synchroniser before the pin read path.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pio_port_bank
  import pio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  input wire logic [15:0] periphEnable,
  input wire logic [15:0] periphDriving,
  input wire logic [15:0] periphOut,
  input wire logic [15:0] padIn,
  output logic [15:0] padOut,
  output logic [15:0] padOutEn_n
);

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  logic [15:0] pinDirection;
  logic [15:0] outputLatch;
  logic [15:0] next_pinDirection;
  logic [15:0] next_outputLatch;
  logic [15:0] pinSync;

  always_comb begin
    next_pinDirection = pinDirection;
    next_outputLatch = outputLatch;
    if (regWrEn) begin
      case (regAddr)
        PIO_OFF_DIR: next_pinDirection = regWrData & PIO_IMPL_MASK; // RULE8
        PIO_OFF_LAT: next_outputLatch = regWrData & PIO_IMPL_MASK; // RULE5
        PIO_OFF_PIN: next_outputLatch = regWrData & PIO_IMPL_MASK; // RULE7
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinDirection <= PIO_DIR_RST & PIO_IMPL_MASK; // RULE4
      outputLatch <= PIO_LAT_RST;
    end else begin
      pinDirection <= next_pinDirection;
      outputLatch <= next_outputLatch;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIO_WIDTH; gi++) begin : g_sync
      pio_sync_bit u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn(padIn[gi]),
        .syncOut(pinSync[gi])
      ); // RULE11
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] next_regRdData;

  always_comb begin
    next_regRdData = 16'h0000;
    if (regRdEn) begin
      case (regAddr)
        PIO_OFF_DIR: next_regRdData = pinDirection & PIO_IMPL_MASK; // RULE8
        PIO_OFF_LAT: next_regRdData = outputLatch & PIO_IMPL_MASK; // RULE5
        PIO_OFF_PIN: next_regRdData = pinSync & PIO_IMPL_MASK; // RULE6
        PIO_OFF_IMPL: next_regRdData = PIO_IMPL_MASK;
        default: next_regRdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // ----------------------------------------------------------------
  // Pad ownership multiplexers
  // ----------------------------------------------------------------
  logic [15:0] periphOwns;
  logic [15:0] next_padOut;
  logic [15:0] next_padOutEn_n;

  always_comb begin
    // Input-only sharers never claim the pad
    periphOwns = periphEnable & periphDriving & ~PIO_INONLY_MASK & PIO_IMPL_MASK; // RULE1 RULE2 RULE9
    next_padOut = 16'h0000;
    next_padOutEn_n = 16'hffff;
    for (int i = 0; i < PIO_WIDTH; i++) begin
      if (!PIO_IMPL_MASK[i]) begin
        next_padOut[i] = 1'b0; // RULE8
        next_padOutEn_n[i] = 1'b1;
      end else if (periphOwns[i]) begin
        next_padOut[i] = periphOut[i]; // RULE10 RULE1
        next_padOutEn_n[i] = 1'b0;
      end else begin
        next_padOut[i] = outputLatch[i]; // RULE10 RULE2
        next_padOutEn_n[i] = pinDirection[i]; // RULE3
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      padOut <= 16'h0000;
      padOutEn_n <= 16'hffff;
    end else begin
      padOut <= next_padOut;
      padOutEn_n <= next_padOutEn_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Direction write that turns bit 0 into an output
  sequence s_dir_bit0_out;
    regWrEn && regAddr == PIO_OFF_DIR && !regWrData[0];
  endsequence

  sequence s_dir_write;
    regWrEn && regAddr == PIO_OFF_DIR;
  endsequence

  sequence s_lat_write;
    regWrEn && regAddr == PIO_OFF_LAT;
  endsequence

  sequence s_dir_read;
    regRdEn && regAddr == PIO_OFF_DIR;
  endsequence

  sequence s_lat_read;
    regRdEn && regAddr == PIO_OFF_LAT;
  endsequence

  sequence s_pin_read;
    regRdEn && regAddr == PIO_OFF_PIN;
  endsequence

  // Index above the last mapped register
  sequence s_unmapped_write;
    regWrEn && regAddr > PIO_OFF_IMPL;
  endsequence

  sequence s_unmapped_read;
    regRdEn && regAddr > PIO_OFF_IMPL;
  endsequence

  AST_RESET_INPUTS: assert property (@(posedge sys_clk) // RULE4
    sys_rst |=> pinDirection == (PIO_DIR_RST & PIO_IMPL_MASK))
    else $error("direction not all inputs after reset");

  AST_PERIPH_OWNS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
    (periphEnable[0] && periphDriving[0] && !PIO_INONLY_MASK[0]) |=>
      (padOutEn_n[0] == 1'b0 && padOut[0] == $past(periphOut[0])))
    else $error("peripheral did not own driving pad");

  AST_PORT_DRIVES: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
    (periphEnable[0] && !periphDriving[0]) |=>
      (padOutEn_n[0] == $past(pinDirection[0]) && padOut[0] == $past(outputLatch[0])))
    else $error("port did not drive idle peripheral pad");

  AST_DIR_INPUT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    (s_dir_bit0_out ##1 !periphEnable[0]) |=> padOutEn_n[0] == 1'b0)
    else $error("cleared direction bit did not enable driver");

  AST_LAT_READBACK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    (regWrEn && regAddr == PIO_OFF_LAT) ##1 (regRdEn && regAddr == PIO_OFF_LAT) |=>
      regRdData == ($past(regWrData, 2) & PIO_IMPL_MASK))
    else $error("latch read does not return written value");

  AST_PIN_READ: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
    (regRdEn && regAddr == PIO_OFF_PIN) |=> regRdData == ($past(pinSync) & PIO_IMPL_MASK))
    else $error("pin read does not show synchronised pins");

  AST_PIN_WRITE_LATCH: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
    (regWrEn && regAddr == PIO_OFF_PIN) |=>
      (outputLatch == ($past(regWrData) & PIO_IMPL_MASK) && $stable(pinDirection)))
    else $error("pin write did not land in latch");

  AST_UNIMPL_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    ((regRdData & ~PIO_IMPL_MASK) == 16'h0000) && ((padOut & ~PIO_IMPL_MASK) == 16'h0000))
    else $error("unimplemented bit not zero");

  AST_INONLY_PORT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
    (periphEnable[8] && periphDriving[8]) |=> padOutEn_n[8] == $past(pinDirection[8]))
    else $error("input-only sharer took the pad");

  AST_SYNC_DELAY: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
    $rose(padIn[0]) ##1 padIn[0] |=> pinSync[0])
    else $error("synchroniser latency wrong");

  AST_MUX_PRIORITY: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE10
    (periphEnable[1] && periphDriving[1] && !pinDirection[1]) |=> padOut[1] == $past(periphOut[1]))
    else $error("port beat peripheral on shared pad");

  // ----------------------------------------------------------------
  // Reset state
  // ----------------------------------------------------------------
  AST_RESET_LATCH: assert property (@(posedge sys_clk) // RULE4
    sys_rst |=> outputLatch == PIO_LAT_RST)
    else $error("latch not cleared by reset");

  AST_RESET_PADS_RELEASED: assert property (@(posedge sys_clk) // RULE4
    sys_rst |=> padOutEn_n == 16'hffff)
    else $error("pad driven during reset");

  AST_RESET_RDDATA: assert property (@(posedge sys_clk) // RULE6
    sys_rst |=> regRdData == 16'h0000)
    else $error("read data not cleared by reset");

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  AST_DIR_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    s_dir_write |=> pinDirection == ($past(regWrData) & PIO_IMPL_MASK))
    else $error("direction write did not land");

  AST_LAT_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    s_lat_write |=> outputLatch == ($past(regWrData) & PIO_IMPL_MASK))
    else $error("latch write did not land");

  AST_DIR_READBACK: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    s_dir_read |=> regRdData == ($past(pinDirection) & PIO_IMPL_MASK))
    else $error("direction read does not return direction");

  AST_LAT_READ: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    s_lat_read |=> regRdData == ($past(outputLatch) & PIO_IMPL_MASK))
    else $error("latch read does not return latch");

  // Read data stand for one cycle only
  AST_IDLE_RDDATA_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
    !regRdEn |=> regRdData == 16'h0000)
    else $error("read data held beyond one cycle");

  AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    s_unmapped_read |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");

  AST_UNMAPPED_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    s_unmapped_write |=> ($stable(pinDirection) && $stable(outputLatch)))
    else $error("unmapped write changed a register");

  // ----------------------------------------------------------------
  // Unimplemented bits
  // ----------------------------------------------------------------
  AST_UNIMPL_DIR: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    (pinDirection & ~PIO_IMPL_MASK) == 16'h0000)
    else $error("unimplemented direction bit set");

  AST_UNIMPL_LAT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    (outputLatch & ~PIO_IMPL_MASK) == 16'h0000)
    else $error("unimplemented latch bit set");

  AST_UNIMPL_PAD_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    (padOutEn_n & ~PIO_IMPL_MASK) == ~PIO_IMPL_MASK)
    else $error("unimplemented pad driven");

  // ----------------------------------------------------------------
  // Pad ownership on other bits
  // ----------------------------------------------------------------
  AST_PERIPH_OWNS_HIGH: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
    (periphEnable[7] && periphDriving[7]) |=>
      (padOutEn_n[7] == 1'b0 && padOut[7] == $past(periphOut[7])))
    else $error("peripheral did not own pad seven");

  AST_PORT_DRIVES_HIGH: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
    (periphEnable[7] && !periphDriving[7]) |=>
      (padOutEn_n[7] == $past(pinDirection[7]) && padOut[7] == $past(outputLatch[7])))
    else $error("port did not drive idle pad seven");

  AST_UNUSED_PERIPH: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    !periphEnable[0] |=> padOutEn_n[0] == $past(pinDirection[0]))
    else $error("direction bit not followed by pad");

  AST_INPUT_RELEASED: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    (!periphEnable[1] && pinDirection[1]) |=> padOutEn_n[1])
    else $error("input pin still driven");

  AST_INONLY_DATA: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
    periphEnable[8] |=> padOut[8] == $past(outputLatch[8]))
    else $error("input-only sharer took pad data");

  AST_OWN_OVER_INPUT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE10
    (periphEnable[2] && periphDriving[2] && pinDirection[2]) |=> !padOutEn_n[2])
    else $error("direction beat peripheral enable");

  // ----------------------------------------------------------------
  // Pin read path
  // ----------------------------------------------------------------
  // The pin still reads while a peripheral owns the driver
  AST_PIN_READ_WHILE_OWNED: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
    (s_pin_read ##0 (periphEnable[0] && periphDriving[0])) |=>
      regRdData[0] == $past(pinSync[0]))
    else $error("owned pin not readable");

  AST_SYNC_FALL: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
    $fell(padIn[0]) ##1 !padIn[0] |=> !pinSync[0])
    else $error("synchroniser fall latency wrong");
endmodule // pio_port_bank
`default_nettype wire

/* File: shared/pio_pkg.sv */
// Package of constants for the parallel I/O port bank
package pio_pkg;
  localparam int PIO_WIDTH = 16;
  localparam int PIO_ADDR_W = 4;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] PIO_OFF_DIR = 4'h0;
  localparam logic [3:0] PIO_OFF_LAT = 4'h1;
  localparam logic [3:0] PIO_OFF_PIN = 4'h2;
  localparam logic [3:0] PIO_OFF_IMPL = 4'h3;
  // Reset values
  localparam logic [15:0] PIO_DIR_RST = 16'hffff;
  localparam logic [15:0] PIO_LAT_RST = 16'h0000;
  // Bits present on this device
  localparam logic [15:0] PIO_IMPL_MASK = 16'h01ff;
  // Bits whose sharing peripheral is input-only, so the port keeps ownership
  localparam logic [15:0] PIO_INONLY_MASK = 16'h0100;
  localparam int PIO_SYNC_STAGES = 2;
endpackage : pio_pkg

/* File: hdl/pio_sync_bit.sv */
// Two-flop synchroniser for one pad input
`timescale 1ns/1ps
`default_nettype none
module pio_sync_bit
  import pio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule // pio_sync_bit
`default_nettype wire

/* File: verification/pio_pad_model.sv */
// Board-side model of the shared pads
`timescale 1ns/1ps
`default_nettype none
module pio_pad_model (
  input wire logic [15:0] padOut,
  input wire logic [15:0] padOutEn_n,
  input wire logic [15:0] extLevel,
  output logic [15:0] padIn
);
  // Driven bits show the chip's level, released bits the board's
  always_comb padIn = (padOut & ~padOutEn_n) | (extLevel & padOutEn_n);
endmodule // pio_pad_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the parallel I/O port bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pio_pkg::*;
  logic sys_clk, sys_rst, regWrEn, regRdEn, rdSeen;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, periphEnable, periphDriving, periphOut;
  logic [15:0] padIn, padOut, padOutEn_n, extLevel, dir, lat, own, expEn_n, expOut;
  logic [15:0] expQ[$];
  int errors, check_count;
  pio_port_bank dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .periphEnable(periphEnable), .periphDriving(periphDriving), .periphOut(periphOut),
    .padIn(padIn), .padOut(padOut), .padOutEn_n(padOutEn_n));
  pio_pad_model pad_u (.padOut(padOut), .padOutEn_n(padOutEn_n), .extLevel(extLevel),
    .padIn(padIn));
  // ----------------------------------------
  // Clock, bus tasks and comparison
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rdSeen === 1'b1) cmp(regRdData, expQ.pop_front());
    rdSeen <= regRdEn & ~sys_rst;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    regRdEn <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    expQ.push_back(e);
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    {regWrEn, regRdEn, regAddr, regWrData} = '0;
    {periphEnable, periphDriving, periphOut, extLevel} = '0;
    void'($urandom(32'he2a84fd1));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(PIO_OFF_DIR, PIO_DIR_RST & PIO_IMPL_MASK);
    rd(PIO_OFF_LAT, PIO_LAT_RST);
    rd(PIO_OFF_IMPL, PIO_IMPL_MASK);
    rd(4'h9, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      dir = 16'($urandom());
      lat = 16'($urandom());
      periphEnable <= 16'($urandom());
      periphDriving <= 16'($urandom());
      periphOut <= 16'($urandom());
      extLevel <= 16'($urandom());
      wr(PIO_OFF_DIR, dir);
      wr(i[0] ? PIO_OFF_PIN : PIO_OFF_LAT, lat);
      wr(4'hc, 16'($urandom()));
      idle(5);
      own = periphEnable & periphDriving & ~PIO_INONLY_MASK & PIO_IMPL_MASK;
      expEn_n = ~own & (dir | ~PIO_IMPL_MASK);
      expOut = ((own & periphOut) | (~own & lat)) & ~expEn_n;
      cmp(padOutEn_n, expEn_n);
      cmp(padOut & ~expEn_n, expOut);
      rd(PIO_OFF_PIN, (expOut | (extLevel & expEn_n)) & PIO_IMPL_MASK);
      rd(PIO_OFF_LAT, lat & PIO_IMPL_MASK);
    end
    wr(PIO_OFF_DIR, 16'h0000);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    rd(PIO_OFF_DIR, PIO_DIR_RST & PIO_IMPL_MASK);
    idle(2);
    print_verdict();
  end
  // Cuts a hang short well beyond the expected run length
  initial begin
    #(50 * 5000);
    errors++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
